/* File: shared/gdd_consts.vh */
// Purpose: shared constants of the gate driver command logic
// Assumes: 8-bit serial commands, MSB first
// Notes:   definitions only
`ifndef GDD_CONSTS_VH
`define GDD_CONSTS_VH

// command opcodes, bits 7:5 of the received word
`define GDD_OP_NULL     3'h0
`define GDD_OP_MASK     3'h1
`define GDD_OP_MODE     3'h2
`define GDD_OP_CLEAR_FAULT_LATCH_CMD    3'h3
`define GDD_OP_DT       3'h4
`define GDD_OP_HI       7
`define GDD_OP_LO       5
// bit 4 selects the upper group in mask and clear commands
`define GDD_GRP_BIT     4
// mode command fields
`define GDD_MODE_LOCK   0
`define GDD_MODE_SIMULTANEOUS_CONDUCTION_MODE 1
`define GDD_MODE_POLICY 3
// deadtime command field
`define GDD_DT_CAL_BIT  0
// status register 0 bit positions
`define GDD_ST_OT       0
`define GDD_ST_DESAT    1
`define GDD_ST_UV       2
`define GDD_ST_OC       3
`define GDD_ST_PHERR    4
`define GDD_ST_FRAME    5
`define GDD_ST_WERR     6
`define GDD_ST_RST      7
// status read selectors
`define GDD_SEL_ST0     2'h0
`define GDD_SEL_ST1     2'h1
`define GDD_SEL_ST2     2'h2
`define GDD_SEL_ST3     2'h3
// reset values
`define GDD_MASK_RST    4'hF
`define GDD_ST0_RST     8'h80
`define GDD_DT_MAX      8'hFF
// calibration counter
`define GDD_CAL_W       13
`define GDD_CAL_SH      4
// timing
`define GDD_CLK_MHZ     100
`define GDD_BLANK_NS    1000

`endif

/* File: hw/gdd_phase.v */
// Purpose: one phase of the gate drive: interlock, deadtime and phase error
// Assumes: requests already synchronised to sys_clk_i
// Notes:   outputs are registered
`timescale 1ns/1ps
module gdd_phase #(
    parameter BLANK_CYC = 16'd100
) (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    input  wire       ce_i,
    // commands
    input  wire       hs_req_i,
    input  wire       ls_req_i,
    input  wire       cmp_i,
    input  wire       simultaneous_conduction_mode_i,
    input  wire       off_i,
    input  wire [7:0] dt_i,
    // drive and error
    output reg        hs_o,
    output reg        ls_o,
    output reg        err_o
);
    reg  [7:0]  dt_cnt_r;
    reg  [15:0] blank_r;
    reg         hs_nxt;
    reg         ls_nxt;
    wire        dt_zero = (dt_cnt_r == 8'h00);

    always @* begin
        if (off_i) begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
        end else if (simultaneous_conduction_mode_i) begin
            hs_nxt = hs_req_i;
            ls_nxt = ls_req_i;
        end else begin
            // a simultaneous request turns neither on, keeping the pair safe
            hs_nxt = hs_req_i & (hs_o | (~ls_req_i & ~ls_o & dt_zero));
            ls_nxt = ls_req_i & (ls_o | (~hs_req_i & ~hs_o & dt_zero));
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hs_o     <= 1'b0;
            ls_o     <= 1'b0;
            err_o    <= 1'b0;
            dt_cnt_r <= 8'h00;
            blank_r  <= 16'h0000;
        end else if (ce_i) begin
            hs_o <= hs_nxt;
            ls_o <= ls_nxt;
            if ((hs_o & ~hs_nxt) | (ls_o & ~ls_nxt)) begin
                dt_cnt_r <= dt_i;
            end else if (!dt_zero) begin
                dt_cnt_r <= dt_cnt_r - 8'h01;
            end
            if ((hs_nxt != hs_o) | (ls_nxt != ls_o)) begin
                blank_r <= BLANK_CYC;
            end else if (blank_r != 16'h0000) begin
                blank_r <= blank_r - 16'h0001;
            end
            // comparator must follow the high side when exactly one side is on
            err_o <= ~simultaneous_conduction_mode_i & (blank_r == 16'h0000) & (hs_o ^ ls_o) & (cmp_i ^ hs_o);
        end
    end
endmodule // gdd_phase

/* File: hw/gdd_ctrl.v */
// Purpose: serial command logic of a three-phase gate pre-driver
// Assumes: sys_clk_i is the internal time base; serial pins are asynchronous
// Notes:   SI sampled on SCLK rise, SO shifted on SCLK fall, MSB first
`timescale 1ns/1ps
`include "gdd_consts.vh"

// Behaviour
// - lower mask bits: overtemperature, desaturation, low-side supply, overcurrent; one enables
// - upper mask bits: phase error, framing error, write error, reset event
// - command 0011 loads upper mask from low nibble; mask resets to all ones
// - phase error is comparator XOR drive state, blanked after drive changes
// - simultaneous-conduction mode blanks the phase error completely
// - reset event flag set at reset and while disabled
// - mode command 010: bit0 lock, bit1 simultaneous conduction, bit3 policy; reset zero
// - lock bit can only be set; cleared by device reset only
// - when locked, mode, deadtime and mask writes are dropped and flag write error
// - simultaneous-conduction mode passes synchronised inputs straight to the drivers unless disabled or shut down
// - otherwise a driver turns on only after deadtime, with the other driver of its phase off and not requested
// - policy zero: desaturation or phase error turns all drivers off until cleared
// - policy one: no shutdown, interrupts still raised when unmasked
// - one mode command may set modes and lock together
// - second transistor waits for deadtime, timed from the turn-off command
// - calibrating deadtime command measures next chip-select pulse, divides by 16
// - stored deadtime is within plus zero, minus one cycle of request
// - zero deadtime command sets deadtime zero, no pulse, interlock kept
// - deadtime is 255 cycles after reset until a deadtime command
// - serial data ignored during calibration pulse; toggles flag framing error
// - status word returned after every command; four status read variants
// - last eight bits act; bit count not multiple of eight is framing error
// - faults latch, clear only by matching clear command, live faults persist
module gdd_ctrl #(
    parameter BLANK_NS = `GDD_BLANK_NS
) (
    // clock, reset, enable
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    input  wire       ce_i,
    // serial port
    input  wire       cs_n_i,
    input  wire       sclk_i,
    input  wire       si_i,
    output reg        so_o,
    output reg        so_oe_o,
    // gate commands and feedback
    input  wire [2:0] hs_in_i,
    input  wire [2:0] ls_in_i,
    input  wire [2:0] phase_cmp_i,
    input  wire [2:0] desat_i,
    input  wire       overtemp_i,
    input  wire       low_side_supply_uv_i,
    input  wire       overcurrent_i,
    input  wire       drv_enable_i,
    // gate drive and interrupt
    output wire [2:0] hs_drv_o,
    output wire [2:0] ls_drv_o,
    output reg        irq_o
);
    localparam BLANK_CYC = (BLANK_NS * `GDD_CLK_MHZ + 999) / 1000;
    localparam NIN = 19;

    // every pin passes two flops; third stage only follows the second for edges
    reg  [NIN-1:0] sy1_r;
    reg  [NIN-1:0] sy2_r;
    reg  [2:0]     sy3_r;
    wire [NIN-1:0] pin_w = {cs_n_i, sclk_i, si_i, hs_in_i, ls_in_i, phase_cmp_i, desat_i,
                            overtemp_i, low_side_supply_uv_i, overcurrent_i, drv_enable_i};
    wire       cs_n   = sy2_r[18];
    wire       sclk   = sy2_r[17];
    wire       si     = sy2_r[16];
    wire [2:0] hs_req = sy2_r[15:13];
    wire [2:0] ls_req = sy2_r[12:10];
    wire [2:0] cmp    = sy2_r[9:7];
    wire [2:0] desat  = sy2_r[6:4];
    wire       ot     = sy2_r[3];
    wire       uv     = sy2_r[2];
    wire       oc     = sy2_r[1];
    wire       en     = sy2_r[0];
    wire       cs_fall = sy3_r[2] & ~cs_n;
    wire       cs_rise = ~sy3_r[2] & cs_n;
    wire       sck_rise = ~sy3_r[1] & sclk;
    wire       sck_fall = sy3_r[1] & ~sclk;
    wire       si_edge  = sy3_r[0] ^ si;

    // serial and command state
    reg  [7:0]            rx_r;
    reg  [7:0]            tx_r;
    reg  [2:0]            bits_r;
    reg                   any_r;
    reg  [1:0]            sel_r;
    reg                   cal_pend_r;
    reg                   cal_act_r;
    reg                   cal_tog_r;
    reg  [`GDD_CAL_W-1:0] cal_cnt_r;
    reg  [3:0]            mask_lo_r;
    reg  [3:0]            mask_hi_r;
    reg                   lock_r;
    reg                   simultaneous_conduction_mode_r;
    reg                   policy_r;
    reg  [7:0]            dt_cal_r;
    reg                   dt_done_r;
    reg                   dt_ovf_r;
    reg                   dt_zero_r;
    reg  [7:0]            st_r;
    wire [2:0]            pherr;

    // command decode at the end of a frame
    wire [2:0] op      = rx_r[`GDD_OP_HI:`GDD_OP_LO];
    wire       frm_ok  = any_r & (bits_r == 3'h0);
    wire       cmd_go  = cs_rise & ~cal_act_r & frm_ok;
    wire       is_wr   = (op == `GDD_OP_MASK) | (op == `GDD_OP_MODE) | (op == `GDD_OP_DT);
    wire       is_bad  = (op > `GDD_OP_DT);
    wire       wr_go   = cmd_go & is_wr & ~lock_r;
    wire       werr_ev = cmd_go & ((is_wr & lock_r) | is_bad);
    wire       frm_ev  = (cs_rise & ~cal_act_r & ~frm_ok) | (cs_rise & cal_act_r & cal_tog_r);
    wire       clr_go  = cmd_go & (op == `GDD_OP_CLEAR_FAULT_LATCH_CMD);
    wire [7:0] clr_vec = ~clr_go ? 8'h00 :
                         (rx_r[`GDD_GRP_BIT] ? {rx_r[3:0], 4'h0} : {4'h0, rx_r[3:0]});

    // live conditions; a set always beats a clear in the same cycle
    wire       any_ph  = |pherr;
    wire [7:0] cond;
    assign cond[`GDD_ST_OT]    = ot;
    assign cond[`GDD_ST_DESAT] = (|desat) | any_ph;
    assign cond[`GDD_ST_UV]    = uv;
    assign cond[`GDD_ST_OC]    = oc;
    assign cond[`GDD_ST_PHERR] = any_ph;
    assign cond[`GDD_ST_FRAME] = frm_ev;
    assign cond[`GDD_ST_WERR]  = werr_ev;
    assign cond[`GDD_ST_RST]   = ~en;
    wire [7:0] st_nxt  = (st_r & ~clr_vec) | cond;

    // deadtime in use and shutdown
    wire [7:0] dt_use  = dt_done_r ? dt_cal_r : `GDD_DT_MAX;
    wire       shut    = ~en | (~policy_r & (st_r[`GDD_ST_DESAT] | st_r[`GDD_ST_PHERR]));
    wire [`GDD_CAL_W-1:0] quo = cal_cnt_r >> `GDD_CAL_SH;

    // status word chosen by the previous command; any command other than a read selects status 0
    reg  [7:0] st_word;
    always @* begin
        case (sel_r)
            `GDD_SEL_ST0: st_word = st_r;
            `GDD_SEL_ST1: st_word = {1'b0, policy_r, dt_zero_r, dt_ovf_r, dt_done_r, 1'b0, simultaneous_conduction_mode_r, lock_r};
            `GDD_SEL_ST2: st_word = {mask_hi_r, mask_lo_r};
            `GDD_SEL_ST3: st_word = dt_cal_r;
            default:      st_word = st_r;
        endcase
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // select resets to its idle high level, so no false frame follows reset
            sy1_r <= {1'b1, {(NIN-1){1'b0}}};
            sy2_r <= {1'b1, {(NIN-1){1'b0}}};
            sy3_r <= 3'h4;
        end else if (ce_i) begin
            sy1_r <= pin_w;
            sy2_r <= sy1_r;
            sy3_r <= {cs_n, sclk, si};
        end
    end

    // serial shift, calibration and command execution
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_r       <= 8'h00;
            tx_r       <= 8'h00;
            bits_r     <= 3'h0;
            any_r      <= 1'b0;
            sel_r      <= `GDD_SEL_ST0;
            cal_pend_r <= 1'b0;
            cal_act_r  <= 1'b0;
            cal_tog_r  <= 1'b0;
            cal_cnt_r  <= {`GDD_CAL_W{1'b0}};
            mask_lo_r  <= `GDD_MASK_RST;
            mask_hi_r  <= `GDD_MASK_RST;
            lock_r     <= 1'b0;
            simultaneous_conduction_mode_r   <= 1'b0;
            policy_r   <= 1'b0;
            dt_cal_r   <= 8'h00;
            dt_done_r  <= 1'b0;
            dt_ovf_r   <= 1'b0;
            dt_zero_r  <= 1'b0;
            st_r       <= `GDD_ST0_RST;
            irq_o      <= 1'b0;
            so_o       <= 1'b0;
            so_oe_o    <= 1'b0;
        end else if (ce_i) begin
            st_r    <= st_nxt;
            irq_o   <= |(st_r & {mask_hi_r, mask_lo_r});
            so_oe_o <= ~cs_n;
            if (cs_fall) begin
                if (cal_pend_r) begin
                    cal_act_r  <= 1'b1;
                    cal_pend_r <= 1'b0;
                    cal_tog_r  <= 1'b0;
                    cal_cnt_r  <= {`GDD_CAL_W{1'b0}};
                end else begin
                    bits_r <= 3'h0;
                    any_r  <= 1'b0;
                end
                tx_r <= st_word;
                so_o <= st_word[7];
            end else if (!cs_n && cal_act_r) begin
                // counter saturates, so an overlong pulse still reads as overflow
                if (cal_cnt_r != {`GDD_CAL_W{1'b1}}) begin
                    cal_cnt_r <= cal_cnt_r + {{(`GDD_CAL_W-1){1'b0}}, 1'b1};
                end
                if (sck_rise | sck_fall | si_edge) begin
                    cal_tog_r <= 1'b1;
                end
            end else if (!cs_n) begin
                if (sck_rise) begin
                    rx_r   <= {rx_r[6:0], si};
                    bits_r <= bits_r + 3'h1;
                    any_r  <= 1'b1;
                end
                if (sck_fall) begin
                    tx_r <= {tx_r[6:0], 1'b0};
                    so_o <= tx_r[6];
                end
            end
            if (cs_rise && cal_act_r) begin
                cal_act_r <= 1'b0;
                dt_done_r <= 1'b1;
                dt_zero_r <= 1'b0;
                if (quo > {{(`GDD_CAL_W-8){1'b0}}, `GDD_DT_MAX}) begin
                    dt_cal_r <= `GDD_DT_MAX;
                    dt_ovf_r <= 1'b1;
                end else begin
                    dt_cal_r <= quo[7:0];
                    dt_ovf_r <= 1'b0;
                end
            end
            if (cmd_go) begin
                sel_r <= (op == `GDD_OP_NULL) ? rx_r[1:0] : `GDD_SEL_ST0;
            end
            if (wr_go) begin
                case (op)
                    `GDD_OP_MASK: begin
                        if (rx_r[`GDD_GRP_BIT]) begin
                            mask_hi_r <= rx_r[3:0];
                        end else begin
                            mask_lo_r <= rx_r[3:0];
                        end
                    end
                    `GDD_OP_MODE: begin
                        // modes and lock load together; lock only blocks later frames
                        simultaneous_conduction_mode_r <= rx_r[`GDD_MODE_SIMULTANEOUS_CONDUCTION_MODE];
                        policy_r <= rx_r[`GDD_MODE_POLICY];
                        lock_r   <= lock_r | rx_r[`GDD_MODE_LOCK];
                    end
                    `GDD_OP_DT: begin
                        if (rx_r[`GDD_DT_CAL_BIT]) begin
                            cal_pend_r <= 1'b1;
                        end else begin
                            dt_cal_r   <= 8'h00;
                            dt_zero_r  <= 1'b1;
                            dt_done_r  <= 1'b1;
                            dt_ovf_r   <= 1'b0;
                            cal_pend_r <= 1'b0;
                        end
                    end
                    default: begin
                        cal_pend_r <= cal_pend_r;
                    end
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_phase
            gdd_phase #(
                .BLANK_CYC (BLANK_CYC[15:0])
            ) u_phase (
                .sys_clk_i (sys_clk_i),
                .rstn_i    (rstn_i),
                .ce_i      (ce_i),
                .hs_req_i  (hs_req[g]),
                .ls_req_i  (ls_req[g]),
                .cmp_i     (cmp[g]),
                .simultaneous_conduction_mode_i  (simultaneous_conduction_mode_r),
                .off_i     (shut),
                .dt_i      (dt_use),
                .hs_o      (hs_drv_o[g]),
                .ls_o      (ls_drv_o[g]),
                .err_o     (pherr[g])
            );
        end
    endgenerate
endmodule // gdd_ctrl

/* File: dv/gdd_host.sv */
// Purpose: host serial controller model driving the command port
// Assumes: link clock of 80 ns, clock and data idle low, select idle high
// Notes:   a released data line falls to its pull-down level
`timescale 1ns/1ps
module gdd_host (
    // clock
    input  wire logic sys_clk_i,
    // serial pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // n bits of w, MSB first; rx keeps the last eight bits seen
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rx);
        rx = 8'h00;
        cs_n_o <= 1'b0;
        clk(8);
        for (int i = n - 1; i >= 0; i--) begin
            si_o <= w[i];
            clk(4);
            sclk_o <= 1'b1;
            rx = {rx[6:0], so_i};
            clk(4);
            sclk_o <= 1'b0;
        end
        clk(4);
        si_o <= 1'b0;
        cs_n_o <= 1'b1;
        clk(10);
    endtask
    // clock and data stay quiet, so the pulse is a clean measurement
    task automatic cal(input int n);
        cs_n_o <= 1'b0;
        clk(n);
        cs_n_o <= 1'b1;
        clk(10);
    endtask
endmodule // gdd_host

/* File: dv/gdd_ctrl_chk.sv */
// Purpose: port-level assertions of the gate driver command logic
// Assumes: clock enable held high, so the pin latencies are fixed
// Notes:   latencies follow the two-flop pin synchronisers
`timescale 1ns/1ps
module gdd_ctrl_chk (
    // clock and reset
    input wire       sys_clk_i,
    input wire       rstn_i,
    // serial port
    input wire       cs_n_i,
    input wire       sclk_i,
    input wire       so_o,
    input wire       so_oe_o,
    // gate side
    input wire [2:0] hs_in_i,
    input wire [2:0] ls_in_i,
    input wire       drv_enable_i,
    input wire [2:0] hs_drv_o,
    input wire [2:0] ls_drv_o,
    input wire       irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sel_oe_on_a: assert property (!cs_n_i [*4] |-> so_oe_o)
        else $error("output enable low while selected");
    sel_oe_off_a: assert property (cs_n_i [*4] |-> !so_oe_o)
        else $error("output enable high while deselected");
    so_hold_a: assert property ((!cs_n_i && sclk_i) [*4] |=> $stable(so_o))
        else $error("serial output moved without clock fall");
    reset_irq_a: assert property ($rose(rstn_i) |-> ##[1:4] irq_o)
        else $error("no interrupt after reset");
    disable_off_a: assert property (!drv_enable_i [*6] |-> hs_drv_o == 3'h0 && ls_drv_o == 3'h0)
        else $error("drivers on while disabled");
    hs_cause_a: assert property ($rose(hs_drv_o[0]) |-> $past(hs_in_i[0], 3))
        else $error("high side on without request");
    ls_cause_a: assert property ($rose(ls_drv_o[0]) |-> $past(ls_in_i[0], 3))
        else $error("low side on without request");
    both_on_a: assert property (hs_drv_o[0] && ls_drv_o[0] |-> $past(hs_in_i[0], 3) && $past(ls_in_i[0], 3))
        else $error("both sides on without both requests");
    irq_drop_a: assert property ($fell(irq_o) |-> cs_n_i && $past(cs_n_i, 3))
        else $error("interrupt dropped outside a command");
    cover property ($rose(hs_drv_o[0]));
    cover property (hs_drv_o[0] && ls_drv_o[0]);
    cover property ($fell(irq_o));
endmodule // gdd_ctrl_chk

bind gdd_ctrl gdd_ctrl_chk u_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .hs_in_i(hs_in_i), .ls_in_i(ls_in_i),
    .drv_enable_i(drv_enable_i), .hs_drv_o(hs_drv_o), .ls_drv_o(ls_drv_o), .irq_o(irq_o)
);

/* File: dv/tb_gdd_ctrl.sv */
// Purpose: self-checking bench of the gate driver command logic
// Assumes: host model drives the serial pins, bench drives the gate side
// Notes:   short blanking so phase faults show after a few cycles
`timescale 1ns/1ps
module tb_gdd_ctrl;
    logic       clk, rstn, en, inj, ot, oc;
    logic [2:0] hs_in, ls_in, desat;
    logic [7:0] s;
    wire        cs_n, sclk, si, so, so_oe, irq;
    wire  [2:0] hs_drv, ls_drv, cmp;
    int         fails, checks_done;
    // phase node follows the high side unless a fault is injected
    assign cmp = hs_drv ^ {3{inj}};
    gdd_ctrl #(.BLANK_NS(50)) DUT (
        .sys_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1),
        .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .hs_in_i(hs_in), .ls_in_i(ls_in), .phase_cmp_i(cmp), .desat_i(desat),
        .overtemp_i(ot), .low_side_supply_uv_i(1'b0), .overcurrent_i(oc),
        .drv_enable_i(en), .hs_drv_o(hs_drv), .ls_drv_o(ls_drv), .irq_o(irq)
    );
    gdd_host h (.sys_clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic w(input logic [7:0] c);
        h.xfer({8'h00, c}, 8, s);
    endtask
    // the word returned is the one chosen by the previous read
    task automatic rd(input logic [1:0] sel);
        w({6'h00, sel});
        w({6'h00, sel});
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic gap(input int lo);
        int g;
        hs_in <= 3'h1;
        ls_in <= 3'h0;
        wait_n(300);
        hs_in <= 3'h0;
        ls_in <= 3'h1;
        g = 0;
        // look at the drive mid-cycle, where it has settled
        for (int i = 0; i < 400 && ls_drv[0] !== 1'b1; i++) begin
            @(negedge clk);
            if (hs_drv[0] === 1'b0 && ls_drv[0] !== 1'b1)
                g++;
        end
        @(posedge clk);
        check({7'h00, g >= lo && g <= lo + 3}, 8'h01, "deadtime gap");
    endtask
    task automatic final_report();
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        final_report();
    end
    initial begin
        {rstn, inj, hs_in, ls_in, desat} = 11'h000;
        en = 1'b1;
        ot = 1'b0;
        oc = 1'b0;
        fails = 0;
        checks_done = 0;
        wait_n(16);
        rstn <= 1'b1;
        wait_n(4);
        check({7'h00, irq}, 8'h01, "irq after reset");
        rd(0);
        check(s, 8'h80, "status0 reset");
        rd(2);
        check(s, 8'hFF, "mask reset");
        rd(1);
        check(s, 8'h00, "mode reset");
        w(8'h20);
        w(8'h35);
        rd(2);
        check(s, 8'h50, "upper mask");
        check({7'h00, irq}, 8'h00, "reset irq masked");
        w(8'h38);
        wait_n(5);
        check({7'h00, irq}, 8'h01, "reset irq enabled");
        w(8'h30);
        w(8'h7F);
        gap(255);
        h.xfer(16'h0000, 7, s);
        rd(0);
        check(s & 8'h20, 8'h20, "framing flag");
        w(8'h72);
        w(8'h81);
        h.cal(328);
        rd(3);
        check(s, 8'h14, "calibrated deadtime");
        gap(20);
        w(8'h80);
        rd(1);
        check(s, 8'h28, "zero deadtime mode");
        gap(0);
        hs_in <= 3'h1;
        wait_n(10);
        check({6'h00, hs_drv[0], ls_drv[0]}, 8'h01, "interlock");
        w(8'h42);
        wait_n(10);
        check({6'h00, hs_drv[0], ls_drv[0]}, 8'h03, "both on");
        rd(1);
        check(s, 8'h2A, "full conduction mode");
        ls_in <= 3'h0;
        inj <= 1'b1;
        wait_n(30);
        inj <= 1'b0;
        rd(0);
        check(s & 8'h10, 8'h00, "phase error blanked");
        w(8'h40);
        w(8'h22);
        desat <= 3'h1;
        wait_n(5);
        desat <= 3'h0;
        wait_n(10);
        check({7'h00, hs_drv[0]}, 8'h00, "shutdown");
        check({7'h00, irq}, 8'h01, "desat irq");
        w(8'h62);
        wait_n(10);
        check({7'h00, hs_drv[0]}, 8'h01, "drive after clear");
        check({7'h00, irq}, 8'h00, "irq cleared");
        w(8'h48);
        desat <= 3'h1;
        wait_n(5);
        desat <= 3'h0;
        wait_n(10);
        check({6'h00, hs_drv[0], irq}, 8'h03, "no shutdown, irq");
        w(8'h62);
        inj <= 1'b1;
        wait_n(30);
        inj <= 1'b0;
        rd(0);
        check(s & 8'h12, 8'h12, "phase error");
        check({7'h00, hs_drv[0]}, 8'h01, "phase error kept on");
        w(8'h71);
        w(8'h62);
        w(8'h49);
        rd(1);
        check(s, 8'h69, "modes with lock");
        w(8'h3F);
        rd(0);
        check(s & 8'h40, 8'h40, "write error");
        rd(2);
        check(s, 8'h02, "mask kept");
        w(8'h40);
        rd(1);
        check(s, 8'h69, "lock held");
        ot <= 1'b1;
        oc <= 1'b1;
        wait_n(5);
        ot <= 1'b0;
        oc <= 1'b0;
        rd(0);
        check(s & 8'h09, 8'h09, "overtemp overcurrent flags");
        check({7'h00, irq}, 8'h00, "overtemp overcurrent masked");
        en <= 1'b0;
        wait_n(10);
        en <= 1'b1;
        rd(0);
        check(s & 8'h80, 8'h80, "disable flag");
        final_report();
    end
endmodule // tb_gdd_ctrl
